// ===== verilog/tcr_router.sv
// trigger and clock routing matrix with an AXI4-Lite register slave
// assumes one clock, inputs synchronous to it, pins resolved outside from lineDriveN
//
// Notes on behaviour
// - four internal signals, each with own code
// - destinations: trigger lines 0-7, start, front
// - direction bit: 0 receives, 1 transmits
// - sample clock can be shared over lines
// - disconnect breaks only the named route
// - clear-all removes every route
// - software trigger for analog input start/stop
// - invalid line, signal or direction rejected
// - start line trigger receive forbidden in slot 2
// - trigger polarity selectable, rising after reset
//
// Implementation choices: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "tcr_map.svh"
module tcr_router
	import tcr_pkg::*;
(
	input wire logic clk,
	input wire logic reset,
	input wire logic [7:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	input wire logic [4:0] slotNumber,
	input wire logic sampleClkSrc,
	input wire logic trigEventSrc,
	input wire logic startTrigSrc,
	input wire logic clockedTrigSrc,
	input wire logic [9:0] lineIn,
	output logic [9:0] lineOut,
	output logic [9:0] lineDriveN,
	output logic rxSampleClk,
	output logic rxTrigEvent,
	output logic rxStartTrig,
	output logic rxClockedTrig,
	output logic softTrigAi
);
	tcr_wstate_type wStateReg, wStateNext;
	tcr_rstate_type rStateReg, rStateNext;
	logic awGotReg, awGotNext, wGotReg, wGotNext, awreadyReg, awreadyNext, wreadyReg, wreadyNext;
	logic bvalidReg, bvalidNext, arreadyReg, arreadyNext, rvalidReg, rvalidNext;
	logic [1:0] brespReg, brespNext, rrespReg, rrespNext;
	logic [7:0] addrReg, addrNext;
	logic [31:0] dataReg, dataNext, rdataReg, rdataNext;
	logic [3:0] strbReg, strbNext;
	logic [2:0] errReg, errNext;
	logic polReg, polNext, softReg, softNext;
	logic [3:0] rxReg, rxNext;
	logic trigPrevReg, trigEdgeReg, trigEdgeNext;
	logic doWrite, routeReq, discReq, clearReq, softReq, cmdOk;
	logic [2:0] cmdErr;
	logic [9:0] lineSet, lineDisc, connValid, connTx;
	logic [3:0] txSignals, rxAny;
	logic [3:0] rxHit [`TCR_NUM_LINES];

	// destination code check, shared by route and disconnect
	function automatic logic lineOk(input logic [3:0] line);
		lineOk = line <= `TCR_LINE_FRONT;
	endfunction

	function automatic logic [2:0] checkCmd(input logic [31:0] d, input logic isRoute, input logic [4:0] slot);
		checkCmd = `TCR_ERR_NONE;
		if (!lineOk(d[`TCR_F_LINE]))
			checkCmd = `TCR_ERR_LINE;
		else if (d[`TCR_F_SIG] > `TCR_SIG_CTRIG)
			checkCmd = `TCR_ERR_SIG;
		else if (isRoute && d[`TCR_F_DIR] > `TCR_DIR_TX)
			checkCmd = `TCR_ERR_DIR;
		else if (isRoute && d[`TCR_F_DIR] != `TCR_DIR_TX && d[`TCR_F_SIG] == `TCR_SIG_TRIG
			&& d[`TCR_F_LINE] == `TCR_LINE_START && slot == `TCR_SLOT_RESTRICTED)
			checkCmd = `TCR_ERR_NOT_START;
	endfunction

	// write channel: address and data taken in either order, response after both
	always_comb
	begin
		wStateNext = wStateReg;
		awGotNext = awGotReg;
		wGotNext = wGotReg;
		awreadyNext = awreadyReg;
		wreadyNext = wreadyReg;
		bvalidNext = bvalidReg;
		brespNext = brespReg;
		addrNext = addrReg;
		dataNext = dataReg;
		strbNext = strbReg;
		doWrite = 1'b0;
		if (awvalid && awreadyReg)
		begin
			awGotNext = 1'b1;
			awreadyNext = 1'b0;
			addrNext = awaddr;
		end
		if (wvalid && wreadyReg)
		begin
			wGotNext = 1'b1;
			wreadyNext = 1'b0;
			dataNext = wdata;
			strbNext = wstrb;
		end
		unique case (wStateReg)
			TCR_W_IDLE:
				if (awGotReg && wGotReg)
				begin
					doWrite = 1'b1;
					awGotNext = 1'b0;
					wGotNext = 1'b0;
					bvalidNext = 1'b1;
					brespNext = (addrReg == `TCR_ADDR_ROUTE || addrReg == `TCR_ADDR_DISC
						|| addrReg == `TCR_ADDR_CTRL) ? `TCR_RESP_OKAY : `TCR_RESP_SLVERR;
					wStateNext = TCR_W_RESP;
				end
			TCR_W_RESP:
				if (bready)
				begin
					bvalidNext = 1'b0;
					awreadyNext = 1'b1;
					wreadyNext = 1'b1;
					wStateNext = TCR_W_IDLE;
				end
		endcase
	end

	// register effects; a partial strobe on the low half is ignored to avoid half-formed commands
	always_comb
	begin
		routeReq = doWrite && addrReg == `TCR_ADDR_ROUTE && strbReg[1:0] == 2'h3;
		discReq = doWrite && addrReg == `TCR_ADDR_DISC && strbReg[1:0] == 2'h3;
		clearReq = doWrite && addrReg == `TCR_ADDR_CTRL && strbReg[0] && dataReg[`TCR_B_CLEAR];
		softReq = doWrite && addrReg == `TCR_ADDR_CTRL && strbReg[0] && dataReg[`TCR_B_SOFT];
		cmdErr = checkCmd(dataReg, routeReq, slotNumber);
		cmdOk = cmdErr == `TCR_ERR_NONE;
		errNext = (routeReq || discReq) ? cmdErr : errReg;
		polNext = (doWrite && addrReg == `TCR_ADDR_CTRL && strbReg[0]) ? dataReg[`TCR_B_POL] : polReg;
		softNext = softReq;
		lineSet = 10'h000;
		lineDisc = 10'h000;
		if (routeReq && cmdOk)
			lineSet[dataReg[`TCR_F_LINE]] = 1'b1;
		if (discReq && cmdOk)
			lineDisc[dataReg[`TCR_F_LINE]] = 1'b1;
	end

	// read channel: data one cycle after the address is taken
	always_comb
	begin
		rStateNext = rStateReg;
		arreadyNext = arreadyReg;
		rvalidNext = rvalidReg;
		rdataNext = rdataReg;
		rrespNext = rrespReg;
		unique case (rStateReg)
			TCR_R_IDLE:
				if (arvalid)
				begin
					arreadyNext = 1'b0;
					rvalidNext = 1'b1;
					rrespNext = `TCR_RESP_OKAY;
					rStateNext = TCR_R_DATA;
					unique case (araddr)
						`TCR_ADDR_CTRL: rdataNext = {29'h0, polReg, 2'h0};
						`TCR_ADDR_STATUS: rdataNext = {29'h0, errReg};
						`TCR_ADDR_CONN: rdataNext = {6'h00, connValid & ~connTx, 6'h00, connValid & connTx};
						`TCR_ADDR_ROUTE, `TCR_ADDR_DISC: rdataNext = 32'h0000_0000;
						default:
						begin
							rdataNext = 32'h0000_0000;
							rrespNext = `TCR_RESP_SLVERR;
						end
					endcase
				end
			TCR_R_DATA:
				if (rready)
				begin
					rvalidNext = 1'b0;
					arreadyNext = 1'b1;
					rStateNext = TCR_R_IDLE;
				end
		endcase
	end

	// internal signals out, received lines in
	assign txSignals = {clockedTrigSrc, startTrigSrc, trigEventSrc, sampleClkSrc};

	genvar gi;
	generate
		for (gi = 0; gi < `TCR_NUM_LINES; gi++)
		begin : g_line
			tcr_line_cell u_cell (
				.clk(clk),
				.reset(reset),
				.setReq(lineSet[gi]),
				.discReq(lineDisc[gi]),
				.clearAll(clearReq),
				.sigCode(dataReg[1:0]),
				.dirTx(dataReg[8]),
				.txSignals(txSignals),
				.lineIn(lineIn[gi]),
				.lineOut(lineOut[gi]),
				.lineDriveN(lineDriveN[gi]),
				.connValid(connValid[gi]),
				.connTx(connTx[gi]),
				.rxHit(rxHit[gi])
			);
		end
	endgenerate

	always_comb
	begin
		rxAny = 4'h0;
		for (int i = 0; i < `TCR_NUM_LINES; i++)
			rxAny = rxAny | rxHit[i];
		rxNext = rxAny;
		// active edge of the received trigger, picked by polarity
		trigEdgeNext = polReg ? (trigPrevReg && !rxReg[1]) : (!trigPrevReg && rxReg[1]);
	end

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			wStateReg <= TCR_W_IDLE;
			rStateReg <= TCR_R_IDLE;
			awGotReg <= 1'b0;
			wGotReg <= 1'b0;
			awreadyReg <= 1'b1;
			wreadyReg <= 1'b1;
			bvalidReg <= 1'b0;
			brespReg <= `TCR_RESP_OKAY;
			addrReg <= 8'h00;
			dataReg <= 32'h0000_0000;
			strbReg <= 4'h0;
			arreadyReg <= 1'b1;
			rvalidReg <= 1'b0;
			rdataReg <= 32'h0000_0000;
			rrespReg <= `TCR_RESP_OKAY;
			errReg <= `TCR_ERR_NONE;
			polReg <= 1'b0;
			softReg <= 1'b0;
			rxReg <= 4'h0;
			trigPrevReg <= 1'b0;
			trigEdgeReg <= 1'b0;
		end
		else
		begin
			wStateReg <= wStateNext;
			rStateReg <= rStateNext;
			awGotReg <= awGotNext;
			wGotReg <= wGotNext;
			awreadyReg <= awreadyNext;
			wreadyReg <= wreadyNext;
			bvalidReg <= bvalidNext;
			brespReg <= brespNext;
			addrReg <= addrNext;
			dataReg <= dataNext;
			strbReg <= strbNext;
			arreadyReg <= arreadyNext;
			rvalidReg <= rvalidNext;
			rdataReg <= rdataNext;
			rrespReg <= rrespNext;
			errReg <= errNext;
			polReg <= polNext;
			softReg <= softNext;
			rxReg <= rxNext;
			trigPrevReg <= rxReg[1];
			trigEdgeReg <= trigEdgeNext;
		end
	end

	assign awready = awreadyReg;
	assign wready = wreadyReg;
	assign bvalid = bvalidReg;
	assign bresp = brespReg;
	assign arready = arreadyReg;
	assign rvalid = rvalidReg;
	assign rdata = rdataReg;
	assign rresp = rrespReg;
	assign rxSampleClk = rxReg[0];
	assign rxTrigEvent = trigEdgeReg;
	assign rxStartTrig = rxReg[2];
	assign rxClockedTrig = rxReg[3];
	assign softTrigAi = softReg;

	sequence bothTaken;
		awGotReg && wGotReg && wStateReg == TCR_W_IDLE;
	endsequence
	sequence respShown;
		bvalidReg ##1 (bvalidReg || $past(bready));
	endsequence

	AST_WRITE_RESP: assert property (@(posedge clk) disable iff (reset)
		bothTaken |=> respShown) else $error("write response not raised after both channels");
	AST_SOFT_PULSE: assert property (@(posedge clk) disable iff (reset)
		softReq |=> softTrigAi ##1 (!softTrigAi || $past(softReq))) else $error("soft trigger not one pulse");
	AST_BAD_LINE: assert property (@(posedge clk) disable iff (reset)
		routeReq && !lineOk(dataReg[`TCR_F_LINE]) |=> errReg == `TCR_ERR_LINE) else $error("bad line accepted");
	AST_BAD_NOCHANGE: assert property (@(posedge clk) disable iff (reset)
		(routeReq || discReq) && !cmdOk && !clearReq |=> $stable(lineDriveN) && $stable(connValid))
		else $error("rejected request changed a route");
	AST_SLOT_START: assert property (@(posedge clk) disable iff (reset)
		routeReq && dataReg[`TCR_F_SIG] == `TCR_SIG_TRIG && dataReg[`TCR_F_LINE] == `TCR_LINE_START
		&& dataReg[`TCR_F_DIR] == 2'h0 && slotNumber == `TCR_SLOT_RESTRICTED
		|=> errReg == `TCR_ERR_NOT_START && connValid == $past(connValid)) else $error("slot 2 start receive allowed");
	AST_CLEAR_ALL: assert property (@(posedge clk) disable iff (reset)
		clearReq |=> connValid == 10'h000 && lineDriveN == 10'h3FF) else $error("clear-all left a route");
	AST_ROUTE_TX: assert property (@(posedge clk) disable iff (reset)
		routeReq && cmdOk && !clearReq && dataReg[`TCR_F_DIR] == `TCR_DIR_TX
		|=> !lineDriveN[$past(dataReg[`TCR_F_LINE])]
		&& lineOut[$past(dataReg[`TCR_F_LINE])] == $past(txSignals[dataReg[1:0]]))
		else $error("transmit route not driving selected signal");
	AST_TRIG_RISE: assert property (@(posedge clk) disable iff (reset)
		!polReg && !trigPrevReg && rxReg[1] |=> rxTrigEvent) else $error("rising trigger edge missed");
endmodule

// ===== verilog/tcr_map.svh
// register map, field positions and codes of the trigger/clock router
// assumes a 32-bit AXI4-Lite slave decoding the low byte of the address
`ifndef TCR_MAP_SVH
`define TCR_MAP_SVH
`define TCR_ADDR_ROUTE 8'h00
`define TCR_ADDR_DISC 8'h04
`define TCR_ADDR_CTRL 8'h08
`define TCR_ADDR_STATUS 8'h0C
`define TCR_ADDR_CONN 8'h10
`define TCR_F_SIG 2:0
`define TCR_F_LINE 7:4
`define TCR_F_DIR 9:8
`define TCR_B_CLEAR 0
`define TCR_B_SOFT 1
`define TCR_B_POL 2
`define TCR_NUM_LINES 10
`define TCR_NUM_SIGS 4
`define TCR_LINE_START 4'h8
`define TCR_LINE_FRONT 4'h9
`define TCR_SIG_SCLK 3'h0
`define TCR_SIG_TRIG 3'h1
`define TCR_SIG_START 3'h2
`define TCR_SIG_CTRIG 3'h3
`define TCR_DIR_TX 2'h1
`define TCR_ERR_NONE 3'h0
`define TCR_ERR_LINE 3'h1
`define TCR_ERR_SIG 3'h2
`define TCR_ERR_DIR 3'h3
`define TCR_ERR_NOT_START 3'h4
`define TCR_SLOT_RESTRICTED 5'h02
`define TCR_RESP_OKAY 2'h0
`define TCR_RESP_SLVERR 2'h2
`endif

// ===== verilog/tcr_pkg.sv
// types shared by the trigger/clock router files
// assumes tcr_map.svh supplies the numeric map
package tcr_pkg;
	typedef enum logic [1:0] {TCR_W_IDLE = 2'b01, TCR_W_RESP = 2'b10} tcr_wstate_type;
	typedef enum logic [1:0] {TCR_R_IDLE = 2'b01, TCR_R_DATA = 2'b10} tcr_rstate_type;
	typedef logic [1:0] tcr_sig_type;
endpackage

// ===== verilog/tcr_line_cell.sv
// one destination line of the router: holds its single connection and drives the pin
// assumes requests are one-cycle pulses already validated by the parent
`timescale 1ns/1ps
module tcr_line_cell
	import tcr_pkg::*;
(
	input wire logic clk,
	input wire logic reset,
	input wire logic setReq,
	input wire logic discReq,
	input wire logic clearAll,
	input wire tcr_sig_type sigCode,
	input wire logic dirTx,
	input wire logic [3:0] txSignals,
	input wire logic lineIn,
	output logic lineOut,
	output logic lineDriveN,
	output logic connValid,
	output logic connTx,
	output logic [3:0] rxHit
);
	logic validReg, validNext, txReg, txNext, outReg, outNext, driveNReg, driveNNext;
	tcr_sig_type sigReg, sigNext;

	always_comb
	begin
		validNext = validReg;
		sigNext = sigReg;
		txNext = txReg;
		if (clearAll)
			validNext = 1'b0;
		else if (setReq)
		begin
			// a new route replaces the old one, so one signal per line at most
			validNext = 1'b1;
			sigNext = sigCode;
			txNext = dirTx;
		end
		else if (discReq && validReg && sigReg == sigCode)
			validNext = 1'b0;
		outNext = txSignals[sigNext];
		driveNNext = !(validNext && txNext);
	end

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			validReg <= 1'b0;
			sigReg <= 2'h0;
			txReg <= 1'b0;
			outReg <= 1'b0;
			driveNReg <= 1'b1;
		end
		else
		begin
			validReg <= validNext;
			sigReg <= sigNext;
			txReg <= txNext;
			outReg <= outNext;
			driveNReg <= driveNNext;
		end
	end

	always_comb
	begin
		rxHit = 4'h0;
		if (validReg && !txReg)
			rxHit[sigReg] = lineIn;
	end

	assign lineOut = outReg;
	assign lineDriveN = driveNReg;
	assign connValid = validReg;
	assign connTx = txReg;

	AST_TX_DRIVES: assert property (@(posedge clk) disable iff (reset)
		setReq && !clearAll && dirTx |=> !lineDriveN) else $error("transmit route did not drive line");
	AST_RX_RELEASES: assert property (@(posedge clk) disable iff (reset)
		setReq && !clearAll && !dirTx |=> lineDriveN && !connTx && sigReg == $past(sigCode)
		&& rxHit == ({3'h0, lineIn} << sigReg))
		else $error("receive route drove line");
	AST_DISC_OTHER_KEEPS: assert property (@(posedge clk) disable iff (reset)
		discReq && !setReq && !clearAll && sigReg != sigCode |=> $stable(validReg) && $stable(lineDriveN))
		else $error("disconnect broke a different route");
endmodule

// ===== bench/tcr_backplane_model.sv
// far side of the router: other backplane modules and the line pull-ups
// assumes lineDriveN low means the router drives that line
`timescale 1ns/1ps
module tcr_backplane_model
	import tcr_pkg::*;
(
	input wire logic [9:0] lineOut,
	input wire logic [9:0] lineDriveN,
	input wire logic [9:0] farEn,
	input wire logic [9:0] farLevel,
	output logic [9:0] lineIn
);
	// far module yields while the router drives, so a line never has two drivers
	// a released line with no far driver floats up to the pull-up level
	always_comb
	begin
		for (int i = 0; i < 10; i++)
			lineIn[i] = !lineDriveN[i] ? lineOut[i] : (farEn[i] ? farLevel[i] : 1'b1);
	end
endmodule

// ===== bench/tb.sv
// self-checking bench of the trigger/clock router over AXI4-Lite
// assumes the router map header and a far-side backplane model
`timescale 1ns/1ps
`include "tcr_map.svh"
module tb
	import tcr_pkg::*;
;
	logic clk, reset, awvalid, wvalid, bready, arvalid, rready;
	logic awready, wready, bvalid, arready, rvalid;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata, rData;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, bResp, rResp;
	logic [4:0] slotNumber;
	logic sampleClkSrc, trigEventSrc, startTrigSrc, clockedTrigSrc;
	logic rxSampleClk, rxTrigEvent, rxStartTrig, rxClockedTrig, softTrigAi;
	logic [9:0] lineIn, lineOut, lineDriveN, farEn, farLevel;
	int mismatches, total_checks, trigPulses, softPulses;

	tcr_router tcr_router_i (.clk(clk), .reset(reset), .awaddr(awaddr), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
		.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.slotNumber(slotNumber), .sampleClkSrc(sampleClkSrc), .trigEventSrc(trigEventSrc),
		.startTrigSrc(startTrigSrc), .clockedTrigSrc(clockedTrigSrc), .lineIn(lineIn),
		.lineOut(lineOut), .lineDriveN(lineDriveN), .rxSampleClk(rxSampleClk),
		.rxTrigEvent(rxTrigEvent), .rxStartTrig(rxStartTrig), .rxClockedTrig(rxClockedTrig),
		.softTrigAi(softTrigAi));
	tcr_backplane_model tcr_backplane_model_i (.lineOut(lineOut), .lineDriveN(lineDriveN),
		.farEn(farEn), .farLevel(farLevel), .lineIn(lineIn));

	initial
	begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	// pulses counted on the falling edge so checks at the rising edge never race them
	always @(negedge clk)
	begin
		if (rxTrigEvent === 1'b1) trigPulses++;
		if (softTrigAi === 1'b1) softPulses++;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		total_checks++;
		if (got !== exp)
		begin
			mismatches++;
			$display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask

	// starts one edge late so bready is never assigned twice in one time step
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do
		begin
			@(posedge clk);
			n++;
			if (awvalid === 1'b1 && awready === 1'b1) awvalid <= 1'b0;
			if (wvalid === 1'b1 && wready === 1'b1) wvalid <= 1'b0;
		end
		while (bvalid !== 1'b1 && n < 50);
		bResp = bresp;
		bready <= 1'b0;
		chk(n < 50, 1, "write answer");
	endtask

	task automatic rd(input logic [7:0] a);
		int n;
		n = 0;
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do
		begin
			@(posedge clk);
			n++;
			if (arvalid === 1'b1 && arready === 1'b1) arvalid <= 1'b0;
		end
		while (rvalid !== 1'b1 && n < 50);
		rData = rdata;
		rResp = rresp;
		rready <= 1'b0;
		chk(n < 50, 1, "read answer");
	endtask

	function automatic logic [31:0] rt(input logic [2:0] s, input logic [3:0] l, input logic [1:0] d);
		return {22'h00_0000, d, l, 1'b0, s};
	endfunction

	task automatic t_reset();
		chk(lineDriveN, 10'h3FF, "reset release");
		rd(`TCR_ADDR_CONN);
		chk(rData, 32'h0000_0000, "reset conn");
		rd(`TCR_ADDR_CTRL);
		chk(rData[2], 1'b0, "reset polarity");
		$display("test reset done");
	endtask

	task automatic t_tx();
		wr(`TCR_ADDR_ROUTE, rt(`TCR_SIG_SCLK, 4'h3, `TCR_DIR_TX));
		chk(bResp, `TCR_RESP_OKAY, "route resp");
		wr(`TCR_ADDR_ROUTE, rt(`TCR_SIG_CTRIG, `TCR_LINE_FRONT, `TCR_DIR_TX));
		wr(`TCR_ADDR_ROUTE, rt(`TCR_SIG_START, 4'h7, `TCR_DIR_TX));
		chk(lineDriveN, 10'h177, "tx enables");
		for (int v = 0; v < 2; v++)
		begin
			sampleClkSrc <= v[0];
			clockedTrigSrc <= !v[0];
			startTrigSrc <= v[0];
			cyc(3);
			chk(lineOut[3], v[0], "clock share");
			chk(lineOut[9], !v[0], "front pin");
			chk(lineOut[7], v[0], "line 7");
		end
		rd(`TCR_ADDR_CONN);
		chk(rData, 32'h0000_0288, "tx conn");
		$display("test transmit done");
	endtask

	task automatic t_rx();
		int base;
		farEn <= 10'h120;
		farLevel <= 10'h000;
		wr(`TCR_ADDR_ROUTE, rt(`TCR_SIG_TRIG, `TCR_LINE_START, 2'h0));
		rd(`TCR_ADDR_STATUS);
		chk(rData[2:0], `TCR_ERR_NONE, "start rx slot 5");
		wr(`TCR_ADDR_ROUTE, rt(`TCR_SIG_START, 4'h5, 2'h0));
		chk(lineDriveN, 10'h177, "rx stays released");
		rd(`TCR_ADDR_CONN);
		chk(rData, 32'h0120_0288, "rx conn");
		base = trigPulses;
		farLevel <= 10'h120;
		cyc(4);
		chk(rxStartTrig, 1'b1, "rx high");
		chk(trigPulses, base + 1, "rising edge");
		farLevel <= 10'h000;
		cyc(4);
		chk(rxStartTrig, 1'b0, "rx low");
		chk(trigPulses, base + 1, "falling ignored");
		wr(`TCR_ADDR_CTRL, 32'h0000_0004);
		farLevel <= 10'h120;
		cyc(4);
		chk(trigPulses, base + 1, "rising ignored");
		farLevel <= 10'h000;
		cyc(4);
		chk(trigPulses, base + 2, "falling edge");
		wr(`TCR_ADDR_CTRL, 32'h0000_0000);
		$display("test receive done");
	endtask

	task automatic t_disc();
		wr(`TCR_ADDR_DISC, rt(`TCR_SIG_TRIG, 4'h3, 2'h0));
		rd(`TCR_ADDR_CONN);
		chk(rData, 32'h0120_0288, "wrong signal kept");
		wr(`TCR_ADDR_DISC, rt(`TCR_SIG_SCLK, 4'h3, 2'h0));
		chk(lineDriveN, 10'h17F, "line released");
		rd(`TCR_ADDR_CONN);
		chk(rData, 32'h0120_0280, "others kept");
		wstrb <= 4'h1;
		wr(`TCR_ADDR_ROUTE, rt(`TCR_SIG_SCLK, 4'h6, `TCR_DIR_TX));
		wstrb <= 4'hF;
		chk(lineDriveN, 10'h17F, "partial strobe ignored");
		$display("test disconnect done");
	endtask

	task automatic t_err();
		logic [31:0] cmd [4] = '{32'h0000_01A0, 32'h0000_0104, 32'h0000_0200, 32'h0000_0081};
		logic [2:0] err [4] = '{`TCR_ERR_LINE, `TCR_ERR_SIG, `TCR_ERR_DIR, `TCR_ERR_NOT_START};
		slotNumber <= `TCR_SLOT_RESTRICTED;
		for (int i = 0; i < 4; i++)
		begin
			wr(`TCR_ADDR_ROUTE, cmd[i]);
			rd(`TCR_ADDR_STATUS);
			chk(rData[2:0], err[i], "error code");
			rd(`TCR_ADDR_CONN);
			chk(rData, 32'h0120_0280, "no route change");
		end
		slotNumber <= 5'h05;
		$display("test errors done");
	endtask

	task automatic t_clear();
		int base;
		farEn <= 10'h123;
		farLevel <= 10'h001;
		wr(`TCR_ADDR_ROUTE, rt(`TCR_SIG_SCLK, 4'h0, 2'h0));
		wr(`TCR_ADDR_ROUTE, rt(`TCR_SIG_CTRIG, 4'h1, 2'h0));
		cyc(3);
		chk({rxSampleClk, rxClockedTrig}, 2'h2, "shared clock in");
		farLevel <= 10'h002;
		cyc(3);
		chk({rxSampleClk, rxClockedTrig}, 2'h1, "clocked trigger in");
		wr(`TCR_ADDR_CTRL, 32'h0000_0001);
		chk(lineDriveN, 10'h3FF, "all released");
		cyc(2);
		chk({rxSampleClk, rxClockedTrig, rxStartTrig}, 3'h0, "rx cleared");
		rd(`TCR_ADDR_CONN);
		chk(rData, 32'h0000_0000, "all cleared");
		base = softPulses;
		wr(`TCR_ADDR_CTRL, 32'h0000_0002);
		cyc(2);
		chk(softPulses, base + 1, "soft trigger");
		wr(8'h40, 32'h0000_0001);
		chk(bResp, `TCR_RESP_SLVERR, "unmapped write");
		rd(8'h40);
		chk(rResp, `TCR_RESP_SLVERR, "unmapped read");
		chk(rData, 32'h0000_0000, "unmapped data");
		$display("test clear and soft done");
	endtask

	task automatic summarize();
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	initial
	begin
		{awvalid, wvalid, bready, arvalid, rready} = 5'h00;
		{awaddr, araddr, wdata, wstrb} = 52'h0_0000_0000_000F;
		{sampleClkSrc, trigEventSrc, startTrigSrc, clockedTrigSrc} = 4'h0;
		{farEn, farLevel} = 20'h0_0000;
		slotNumber = 5'h05;
		{mismatches, total_checks, trigPulses, softPulses} = 128'h0;
		reset = 1'b1;
		cyc(12);
		reset <= 1'b0;
		t_reset();
		t_tx();
		t_rx();
		t_disc();
		t_err();
		t_clear();
		summarize();
	end

	// the whole run needs some hundred cycles; this span of 40000 cycles leaves wide margin
	initial
	begin
		#200000;
		mismatches++;
		$display("MISMATCH t=%0t watchdog expired", $time);
		summarize();
	end
endmodule
